// file: logic/rab_bridge.sv
// Addressed bridge between a half-duplex network port and a serial port.
//
// What this block does
// - Holds one node address, 0 to 255.
// - Answers to address 0 after reset.
// - Host selects one of many bridges.
// - Passes characters on without frame buffering.
// - One shared pair, one driver at once.
// - Senses direction itself, switches own driver.
`timescale 1ns/1ps
`default_nettype none
module rab_bridge (
  // Clock and reset
  input wire logic clk,
  input wire logic resetn,
  // Network pair, as receiver input, driver input and driver enable
  input wire logic netLineIn,
  output logic netLineOut,
  output logic netLineOe_n,
  // Instrument serial port
  input wire logic serRxd,
  output logic serTxd,
  // Address reconfiguration
  input wire logic [7:0] cfgAddr,
  input wire logic cfgAddrLoad,
  // Status
  output logic nodeSelected,
  output logic charDropped
);
  // ---------------------------------------------------------------
  // Declarations
  // ---------------------------------------------------------------
  logic [7:0] nodeAddr_q;
  rab_pkg::rab_frame_t state_q;
  logic [7:0] addrAcc_q;
  logic [1:0] hexCnt_q;
  logic selected_q;
  logic pushValid_q;
  logic [7:0] pushData_q;
  logic respPend_q;
  logic [7:0] respData_q;
  logic charDropped_q;
  logic netLineOe_n_q;
  logic netRxLine;
  logic [7:0] netRxData;
  logic netRxValid;
  logic [7:0] serRxData;
  logic serRxValid;
  logic fifoInReady;
  logic fifoOutValid;
  logic [7:0] fifoOutData;
  logic [1:0] txLoad;
  logic [1:0] txEnd;
  logic [7:0] txByte [2];
  logic [1:0] txBusy_q;
  logic [1:0] txLine_q;
  logic [4:0] hexDec;
  logic [3:0] isHex;
  logic hexOk;
  logic [7:0] addrNext;

  // ---------------------------------------------------------------
  // Hex digit decode
  // ---------------------------------------------------------------
  function automatic logic [4:0] hexVal(input logic [7:0] ch);
    logic [4:0] r;
    r = 5'h10;
    if (ch >= 8'h30 && ch <= 8'h39) begin
      r = {1'b0, 4'(ch - 8'h30)};
    end else if (ch >= 8'h41 && ch <= 8'h46) begin
      r = {1'b0, 4'(ch - 8'h37)};
    end else if (ch >= 8'h61 && ch <= 8'h66) begin
      r = {1'b0, 4'(ch - 8'h57)};
    end
    return r;
  endfunction

  assign hexDec = hexVal(netRxData);
  assign isHex = hexDec[3:0];
  assign hexOk = !hexDec[4];
  assign addrNext = {addrAcc_q[3:0], isHex};

  // ---------------------------------------------------------------
  // Node address
  // ---------------------------------------------------------------
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      nodeAddr_q <= rab_pkg::ADDR_RESET;
    end else if (cfgAddrLoad) begin
      nodeAddr_q <= cfgAddr;
    end
  end

  // ---------------------------------------------------------------
  // Receivers
  // ---------------------------------------------------------------
  // While our own driver is on, the receiver would hear our own answer.
  assign netRxLine = netLineOe_n_q ? netLineIn : 1'b1;

  rab_uart_rx uNetRx (
    .clk(clk),
    .resetn(resetn),
    .lineIn(netRxLine),
    .rxData(netRxData),
    .rxValid(netRxValid)
  );

  rab_uart_rx uSerRx (
    .clk(clk),
    .resetn(resetn),
    .lineIn(serRxd),
    .rxData(serRxData),
    .rxValid(serRxValid)
  );

  // ---------------------------------------------------------------
  // Frame parser
  // ---------------------------------------------------------------
  // A brace restarts framing from any state, so a broken frame cannot
  // leave the bridge stuck forwarding.
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      state_q <= rab_pkg::FR_IDLE;
      addrAcc_q <= '0;
      hexCnt_q <= '0;
      selected_q <= 1'b0;
    end else if (netRxValid) begin
      if (netRxData == rab_pkg::CH_DELIM) begin
        state_q <= rab_pkg::FR_ADDR;
        addrAcc_q <= '0;
        hexCnt_q <= '0;
      end else begin
        case (state_q)
          rab_pkg::FR_ADDR: begin
            if (!hexOk) begin
              state_q <= rab_pkg::FR_IDLE;
            end else if (hexCnt_q == rab_pkg::ADDR_CHARS - 2'h1) begin
              selected_q <= (addrNext == nodeAddr_q);
              state_q <= (addrNext == nodeAddr_q) ? rab_pkg::FR_FWD
                                                  : rab_pkg::FR_SKIP;
            end else begin
              addrAcc_q <= addrNext;
              hexCnt_q <= hexCnt_q + 2'h1;
            end
          end
          rab_pkg::FR_FWD: begin
            if (netRxData == rab_pkg::CH_CR) begin
              state_q <= rab_pkg::FR_IDLE;
            end
          end
          rab_pkg::FR_SKIP: begin
            if (netRxData == rab_pkg::CH_CR) begin
              state_q <= rab_pkg::FR_IDLE;
            end
          end
          default: begin
            state_q <= rab_pkg::FR_IDLE;
          end
        endcase
      end
    end
  end

  // ---------------------------------------------------------------
  // Host to instrument path
  // ---------------------------------------------------------------
  // Only the command text and its closing CR go on; the brace and the
  // address characters never reach the instrument.
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      pushValid_q <= 1'b0;
      pushData_q <= '0;
    end else begin
      if (pushValid_q && fifoInReady) begin
        pushValid_q <= 1'b0;
      end
      if (netRxValid && state_q == rab_pkg::FR_FWD &&
          netRxData != rab_pkg::CH_DELIM && !pushValid_q) begin
        pushValid_q <= 1'b1;
        pushData_q <= netRxData;
      end
    end
  end

  // The FIFO only rides out the skew between the two bit clocks; at
  // equal baud rates it never holds more than the character in transit.
  rab_fifo #(
    .WIDTH(8),
    .DEPTH(rab_pkg::FIFO_DEPTH)
  ) uFifo (
    .clk(clk),
    .resetn(resetn),
    .inValid(pushValid_q),
    .inReady(fifoInReady),
    .inData(pushData_q),
    .outValid(fifoOutValid),
    .outReady(txLoad[0]),
    .outData(fifoOutData)
  );

  assign txLoad[0] = fifoOutValid && !txBusy_q[0];
  assign txByte[0] = fifoOutData;

  // ---------------------------------------------------------------
  // Instrument to host path
  // ---------------------------------------------------------------
  // Answers go out only while this node holds the selection, so the
  // instruments behind other bridges never collide on the pair.
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      respPend_q <= 1'b0;
      respData_q <= '0;
    end else begin
      if (txLoad[1]) begin
        respPend_q <= 1'b0;
      end
      if (serRxValid && selected_q) begin
        respPend_q <= 1'b1;
        respData_q <= serRxData;
      end
    end
  end

  assign txLoad[1] = respPend_q && !txBusy_q[1];
  assign txByte[1] = respData_q;

  // ---------------------------------------------------------------
  // Dropped characters
  // ---------------------------------------------------------------
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      charDropped_q <= 1'b0;
    end else begin
      charDropped_q <= (netRxValid && state_q == rab_pkg::FR_FWD &&
                        netRxData != rab_pkg::CH_DELIM && pushValid_q) ||
                       (serRxValid && selected_q && respPend_q && !txLoad[1]);
    end
  end

  // ---------------------------------------------------------------
  // Transmitters, 0 to the instrument and 1 to the network
  // ---------------------------------------------------------------
  for (genvar i = 0; i < 2; i++) begin : gTx
    logic [rab_pkg::CNT_W-1:0] cnt_q;
    logic [3:0] bitIdx_q;
    logic [9:0] frame_q;

    assign txEnd[i] = txBusy_q[i] && (cnt_q == '0) &&
                      (bitIdx_q == rab_pkg::FRAME_LAST_BIT);

    always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
        txBusy_q[i] <= 1'b0;
        txLine_q[i] <= 1'b1;
        cnt_q <= '0;
        bitIdx_q <= '0;
        frame_q <= '1;
      end else if (txLoad[i]) begin
        txBusy_q[i] <= 1'b1;
        txLine_q[i] <= 1'b0;
        cnt_q <= rab_pkg::CNT_W'(rab_pkg::BIT_CYCLES - 1);
        bitIdx_q <= '0;
        frame_q <= {1'b1, txByte[i], 1'b0};
      end else if (txBusy_q[i]) begin
        if (cnt_q != '0) begin
          cnt_q <= cnt_q - 1'b1;
        end else if (txEnd[i]) begin
          txBusy_q[i] <= 1'b0;
        end else begin
          cnt_q <= rab_pkg::CNT_W'(rab_pkg::BIT_CYCLES - 1);
          bitIdx_q <= bitIdx_q + 4'h1;
          frame_q <= {1'b1, frame_q[9:1]};
          txLine_q[i] <= frame_q[1];
        end
      end
    end
  end

  // ---------------------------------------------------------------
  // Automatic direction control
  // ---------------------------------------------------------------
  // The driver is enabled from the start bit of an answer character to
  // the end of its stop bit; no handshake line is looked at.
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      netLineOe_n_q <= 1'b1;
    end else begin
      netLineOe_n_q <= !(txLoad[1] || (txBusy_q[1] && !txEnd[1]));
    end
  end

  // ---------------------------------------------------------------
  // Outputs
  // ---------------------------------------------------------------
  assign serTxd = txLine_q[0];
  assign netLineOut = txLine_q[1];
  assign netLineOe_n = netLineOe_n_q;
  assign nodeSelected = selected_q;
  assign charDropped = charDropped_q;
endmodule
`default_nettype wire

// file: pkg/rab_pkg.sv
// Shared constants and types of the addressed serial bridge.
`default_nettype none
package rab_pkg;
  // ---------------------------------------------------------------
  // Timing
  // ---------------------------------------------------------------
  localparam int CLK_HZ = 40_000_000;
  localparam int BAUD_RATE = 19200;
  localparam int BIT_CYCLES = CLK_HZ / BAUD_RATE;
  localparam int HALF_BIT_CYCLES = BIT_CYCLES / 2;
  localparam int CNT_W = 12;
  // ---------------------------------------------------------------
  // Character format
  // ---------------------------------------------------------------
  localparam int DATA_BITS = 8;
  localparam logic [3:0] STOP_BIT_IDX = 4'h9;
  localparam logic [3:0] FRAME_LAST_BIT = 4'h9;
  // ---------------------------------------------------------------
  // Framing and addressing
  // ---------------------------------------------------------------
  localparam logic [7:0] ADDR_RESET = 8'h00;
  localparam logic [1:0] ADDR_CHARS = 2'h2;
  localparam logic [7:0] CH_DELIM = 8'h7B;
  localparam logic [7:0] CH_NL = 8'h0A;
  localparam logic [7:0] CH_CR = 8'h0D;
  localparam int FIFO_DEPTH = 4;
  typedef enum logic [3:0] {
    FR_IDLE = 4'b0001,
    FR_ADDR = 4'b0010,
    FR_FWD  = 4'b0100,
    FR_SKIP = 4'b1000
  } rab_frame_t;
endpackage
`default_nettype wire

// file: logic/rab_fifo.sv
// Small synchronous FIFO with valid and ready on both sides.
`timescale 1ns/1ps
`default_nettype none
module rab_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 4
) (
  // Clock and reset
  input wire logic clk,
  input wire logic resetn,
  // Fill side
  input wire logic inValid,
  output logic inReady,
  input wire logic [WIDTH-1:0] inData,
  // Drain side
  output logic outValid,
  input wire logic outReady,
  output logic [WIDTH-1:0] outData
);
  localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  logic [WIDTH-1:0] mem [DEPTH];
  logic [PW-1:0] wrPtr_q;
  logic [PW-1:0] rdPtr_q;
  logic [PW:0] count_q;
  logic push;
  logic pop;

  assign inReady = (count_q != (PW+1)'(DEPTH));
  assign outValid = (count_q != '0);
  assign outData = mem[rdPtr_q];
  assign push = inValid && inReady;
  assign pop = outValid && outReady;

  always_ff @(posedge clk) begin
    if (push) begin
      mem[wrPtr_q] <= inData;
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      wrPtr_q <= '0;
      rdPtr_q <= '0;
      count_q <= '0;
    end else begin
      if (push) begin
        wrPtr_q <= (wrPtr_q == PW'(DEPTH - 1)) ? '0 : wrPtr_q + 1'b1;
      end
      if (pop) begin
        rdPtr_q <= (rdPtr_q == PW'(DEPTH - 1)) ? '0 : rdPtr_q + 1'b1;
      end
      if (push && !pop) begin
        count_q <= count_q + 1'b1;
      end else if (pop && !push) begin
        count_q <= count_q - 1'b1;
      end
    end
  end
endmodule
`default_nettype wire

// file: logic/rab_uart_rx.sv
// Asynchronous serial character receiver, 8N1, idle high.
`timescale 1ns/1ps
`default_nettype none
module rab_uart_rx (
  // Clock and reset
  input wire logic clk,
  input wire logic resetn,
  // Serial line
  input wire logic lineIn,
  // Received character
  output logic [7:0] rxData,
  output logic rxValid
);
  logic busy_q;
  logic [rab_pkg::CNT_W-1:0] cnt_q;
  logic [3:0] bitIdx_q;
  logic [7:0] shift_q;
  logic [7:0] rxData_q;
  logic rxValid_q;

  assign rxData = rxData_q;
  assign rxValid = rxValid_q;

  // Sampling sits in the middle of each bit, found from the start edge.
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      busy_q <= 1'b0;
      cnt_q <= '0;
      bitIdx_q <= '0;
      shift_q <= '0;
      rxData_q <= '0;
      rxValid_q <= 1'b0;
    end else begin
      rxValid_q <= 1'b0;
      if (!busy_q) begin
        if (!lineIn) begin
          busy_q <= 1'b1;
          cnt_q <= rab_pkg::CNT_W'(rab_pkg::HALF_BIT_CYCLES - 1);
          bitIdx_q <= '0;
        end
      end else if (cnt_q == '0) begin
        cnt_q <= rab_pkg::CNT_W'(rab_pkg::BIT_CYCLES - 1);
        bitIdx_q <= bitIdx_q + 4'h1;
        if (bitIdx_q == rab_pkg::STOP_BIT_IDX) begin
          // A character without a valid stop bit is thrown away.
          busy_q <= 1'b0;
          rxValid_q <= lineIn;
          rxData_q <= shift_q;
        end else if (bitIdx_q == 4'h0) begin
          busy_q <= !lineIn;
        end else begin
          shift_q <= {lineIn, shift_q[7:1]};
        end
      end else begin
        cnt_q <= cnt_q - 1'b1;
      end
    end
  end
endmodule
`default_nettype wire

// file: tb/rab_bridge_properties.sv
// Port-level concurrent checks of the addressed serial bridge.
`timescale 1ns/1ps
`default_nettype none
module rab_bridge_properties (
  // Clock and reset
  input wire logic clk,
  input wire logic resetn,
  // Network pins
  input wire logic netLineIn,
  input wire logic netLineOut,
  input wire logic netLineOe_n,
  // Serial pins
  input wire logic serRxd,
  input wire logic serTxd,
  // Configuration and status
  input wire logic [7:0] cfgAddr,
  input wire logic cfgAddrLoad,
  input wire logic nodeSelected,
  input wire logic charDropped
);
  logic [15:0] oeCnt_q;
  logic [15:0] serLow_q;
  default clocking @(posedge clk); endclocking
  default disable iff (!resetn);
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) oeCnt_q <= 16'h0000;
    else oeCnt_q <= netLineOe_n ? 16'h0000 : oeCnt_q + 16'h0001;
  end
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) serLow_q <= 16'h0000;
    else serLow_q <= serTxd ? 16'h0000 : serLow_q + 16'h0001;
  end
  property p_resetIdle;
    $rose(resetn) |-> netLineOe_n && netLineOut && serTxd && !nodeSelected;
  endproperty
  a_resetIdle: assert property (p_resetIdle) else $error("idle state wrong after reset");
  property p_oeStart;
    $fell(netLineOe_n) |-> !netLineOut && $past(nodeSelected);
  endproperty
  a_oeStart: assert property (p_oeStart) else $error("driver enabled wrongly");
  // Ten bit times exactly; a longer hold would collide with the next host frame.
  property p_oeLength;
    $rose(netLineOe_n) |-> oeCnt_q == 16'h515E;
  endproperty
  a_oeLength: assert property (p_oeLength) else $error("driver enable length wrong");
  property p_releasedHigh;
    netLineOe_n |-> netLineOut;
  endproperty
  a_releasedHigh: assert property (p_releasedHigh) else $error("driver data not idle");
  property p_serBitTime;
    $rose(serTxd) |-> serLow_q != 16'h0000 && (serLow_q % rab_pkg::BIT_CYCLES) == 0;
  endproperty
  a_serBitTime: assert property (p_serBitTime) else $error("serial bit time wrong");
  property p_fwdSelected;
    $fell(serTxd) |-> nodeSelected;
  endproperty
  a_fwdSelected: assert property (p_fwdSelected) else $error("forwarded while unselected");
  property p_dropPulse;
    charDropped |=> !charDropped;
  endproperty
  a_dropPulse: assert property (p_dropPulse) else $error("drop pulse too long");
  property p_loadQuiet;
    cfgAddrLoad |=> $stable(nodeSelected);
  endproperty
  a_loadQuiet: assert property (p_loadQuiet) else $error("load changed selection");
  c_reply: cover property ($fell(netLineOe_n));
  c_forward: cover property ($fell(serTxd));
  c_select: cover property ($rose(nodeSelected));
endmodule
`default_nettype wire

// file: tb/rab_host_model.sv
// Network host that sends framed commands on the shared pair.
`timescale 1ns/1ps
`default_nettype none
module rab_host_model (
  // Clock
  input wire logic clk,
  // Line drive
  output logic hostTx,
  output logic hostOe_n
);
  initial begin
    hostTx = 1'b1;
    hostOe_n = 1'b1;
  end
  // Drives the data line and hostOe_n; the enable is released after the stop bit.
  task automatic sendChar(input logic [7:0] c);
    logic [9:0] f;
    f = {1'b1, c, 1'b0};
    @(posedge clk);
    #1;
    hostOe_n = 1'b0;
    for (int i = 0; i < 10; i++) begin
      hostTx = f[i];
      repeat (rab_pkg::BIT_CYCLES) @(posedge clk);
      #1;
    end
    hostOe_n = 1'b1;
    hostTx = 1'b1;
  endtask
  function automatic logic [7:0] hexChar(input logic [3:0] n);
    return (n < 4'hA) ? 8'h30 + n : 8'h37 + n;
  endfunction
  // Delimiter then two hex digits, high nibble first, picks one bridge.
  task automatic sendHdr(input logic [7:0] a);
    sendChar(8'h7B);
    sendChar(hexChar(a[7:4]));
    sendChar(hexChar(a[3:0]));
  endtask
endmodule
`default_nettype wire

// file: tb/rab_bridge_tb_top.sv
// Self-checking bench of the addressed serial bridge.
`timescale 1ns/1ps
`default_nettype none
module rab_bridge_tb_top;
  logic clk, resetn, serRxd, cfgAddrLoad;
  logic [7:0] cfgAddr;
  logic netLineOut, netLineOe_n, serTxd, nodeSelected, charDropped, hostTx, hostOe_n;
  int mismatches, samplesChecked, dropsSeen;
  // The pair is biased high when nobody drives it.
  wire logic netLine = !netLineOe_n ? netLineOut : (!hostOe_n ? hostTx : 1'b1);
  rab_bridge dut_u (.clk(clk), .resetn(resetn), .netLineIn(netLine),
    .netLineOut(netLineOut), .netLineOe_n(netLineOe_n), .serRxd(serRxd),
    .serTxd(serTxd), .cfgAddr(cfgAddr), .cfgAddrLoad(cfgAddrLoad),
    .nodeSelected(nodeSelected), .charDropped(charDropped));
  rab_host_model host_u (.clk(clk), .hostTx(hostTx), .hostOe_n(hostOe_n));
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  // Characters arrive at line rate, so a drop pulse is never expected.
  always @(posedge clk) begin
    if (resetn === 1'b1 && charDropped !== 1'b0) begin
      dropsSeen++;
    end
  end
  task automatic end_of_test();
    if (mismatches == 0 && samplesChecked > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  task automatic check(input string what, input logic [7:0] exp, input logic [7:0] got);
    samplesChecked++;
    if (got !== exp) begin
      $display("ERROR %s expected %h seen %h", what, exp, got);
      mismatches++;
    end
  endtask
  // Receives one 8N1 character from the network pair or the serial output.
  task automatic getChar(input bit fromNet, output logic [7:0] c);
    int n;
    n = 0;
    while ((fromNet ? netLine : serTxd) !== 1'b0) begin
      @(posedge clk);
      #2;
      n++;
      // A whole header can pass before the first forwarded start bit.
      if (n > 5 * 10 * rab_pkg::BIT_CYCLES) begin
        $display("ERROR start bit expected 0 seen 1");
        mismatches++;
        end_of_test();
      end
    end
    repeat (rab_pkg::HALF_BIT_CYCLES) @(posedge clk);
    #2;
    check("start bit", 8'h00, {7'h00, fromNet ? netLine : serTxd});
    for (int i = 0; i < 8; i++) begin
      repeat (rab_pkg::BIT_CYCLES) @(posedge clk);
      #2;
      c[i] = fromNet ? netLine : serTxd;
    end
    repeat (rab_pkg::BIT_CYCLES) @(posedge clk);
    #2;
    check("stop bit", 8'h01, {7'h00, fromNet ? netLine : serTxd});
  endtask
  task automatic serSend(input logic [7:0] c);
    logic [9:0] f;
    f = {1'b1, c, 1'b0};
    for (int i = 0; i < 10; i++) begin
      @(posedge clk);
      #1;
      serRxd = f[i];
      repeat (rab_pkg::BIT_CYCLES - 1) @(posedge clk);
    end
  endtask
  // Default address selects; only the command text reaches the instrument.
  task automatic sc_defaultSelect();
    logic [7:0] c;
    fork
      begin
        host_u.sendHdr(8'h00);
        host_u.sendChar(8'h5A);
        check("forward latency", 8'h00, {7'h00, serTxd});
      end
      getChar(1'b0, c);
    join
    check("forwarded char", 8'h5A, c);
    check("selected", 8'h01, {7'h00, nodeSelected});
  endtask
  // Instrument answer goes back on the pair with the driver turned on by the bridge.
  task automatic sc_reply();
    logic [7:0] c;
    fork
      serSend(8'h4B);
      getChar(1'b1, c);
    join
    check("reply char", 8'h4B, c);
    repeat (rab_pkg::BIT_CYCLES) @(posedge clk);
    #2;
    check("driver released", 8'h01, {7'h00, netLineOe_n});
  endtask
  // A new node address makes frames for address 0 foreign.
  task automatic sc_reconfig();
    @(posedge clk);
    #1;
    cfgAddr = 8'h3C;
    cfgAddrLoad = 1'b1;
    @(posedge clk);
    #1;
    cfgAddrLoad = 1'b0;
    host_u.sendHdr(8'h00);
    repeat (4) @(posedge clk);
    #2;
    check("deselected", 8'h00, {7'h00, nodeSelected});
    check("serial idle", 8'h01, {7'h00, serTxd});
    check("char dropped pulses", 8'h00, 8'(dropsSeen));
  endtask
  initial begin
    mismatches = 0;
    samplesChecked = 0;
    dropsSeen = 0;
    resetn = 1'b0;
    serRxd = 1'b1;
    cfgAddr = 8'h00;
    cfgAddrLoad = 1'b0;
    repeat (3) @(posedge clk);
    #1;
    resetn = 1'b1;
    sc_defaultSelect();
    sc_reply();
    sc_reconfig();
    end_of_test();
  end
endmodule
bind rab_bridge rab_bridge_properties chk_u (.clk(clk), .resetn(resetn),
  .netLineIn(netLineIn), .netLineOut(netLineOut), .netLineOe_n(netLineOe_n),
  .serRxd(serRxd), .serTxd(serTxd), .cfgAddr(cfgAddr), .cfgAddrLoad(cfgAddrLoad),
  .nodeSelected(nodeSelected), .charDropped(charDropped));
`default_nettype wire
